// >>> pcwo_pkg.sv
// Package of constants and carrier types for the two-channel pulse counter with window outputs.
// Functional notes
// - Freeze true holds count; false does nothing.
// - Allowed active index input loads preload value.
// - Allowed active limit input loads preload value.
// - Two readable window outputs active within range.
// - Window off unless range programmed and armed.
// - Window turns on when count equals low.
// - Window turns off at high; zero at rollover.
// - Arm setting enables range; false disables output.
// - Two pulse inputs, zero to 15 kHz each.
// - Channels are fully independent of each other.
// - Six general-purpose inputs readable by host.
// - Count only while enabled; count is 32-bit.
// - Software disable yields to active external enable.
// - Soft clear resets count; external clear also.
// - Setting permits external enable per channel.
// - Setting permits external clear per channel.
// - Filter code sets maximum counted pulse frequency.
// - Filter selects 15 kHz after reset.
// - Preload only by command, index or limit.
package pcwo_pkg;

  // ==========================================================================
  // Sizes and timing.
  localparam int NUM_CH = 2;
  localparam int NUM_WIN = 2;
  localparam int NUM_GP = 6;
  localparam int CLK_KHZ = 40000;
  localparam int SAMPLE_NS = 16667;
  localparam int SAMPLE_CYCLES = (SAMPLE_NS * CLK_KHZ) / 1000000;
  localparam logic [7:0] FILTER_RESET = 8'h02;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [4:0] CH_CTRL_OFF = 5'h00;
  localparam logic [4:0] CH_PRELOAD_OFF = 5'h04;
  localparam logic [4:0] CH_FILTER_OFF = 5'h08;
  localparam logic [4:0] CH_COUNT_OFF = 5'h0c;
  localparam logic [4:0] CH_STATUS_OFF = 5'h10;
  localparam logic [7:0] WIN_BASE = 8'h40;
  localparam logic [3:0] WIN_LOW_OFF = 4'h0;
  localparam logic [3:0] WIN_HIGH_OFF = 4'h4;
  localparam logic [3:0] WIN_ARM_OFF = 4'h8;
  localparam logic [7:0] WIN_STATUS_ADDR = 8'h60;
  localparam logic [7:0] GP_INPUT_ADDR = 8'h64;

  // ==========================================================================
  // Control register bit positions.
  localparam int CTRL_SW_ENABLE = 0;
  localparam int CTRL_SOFT_CLEAR = 1;
  localparam int CTRL_FREEZE = 2;
  localparam int CTRL_INDEX_ALLOW = 3;
  localparam int CTRL_LIMIT_ALLOW = 4;
  localparam int CTRL_EXT_EN_ALLOW = 5;
  localparam int CTRL_EXT_CLR_ALLOW = 6;
  localparam int CTRL_PRELOAD_NOW = 7;

  // ==========================================================================
  // Carrier types.
  typedef struct packed {
    logic sw_enable;
    logic soft_clear;
    logic count_freeze;
    logic index_preset_allow;
    logic limit_preset_allow;
    logic ext_enable_allow;
    logic ext_clear_allow;
    logic preload_now;
    logic [7:0] glitch_filter_select;
    logic [31:0] preload;
  } pcwo_chan_cfg_s;

  typedef struct packed {
    logic pulse;
    logic index;
    logic limit_switch_input;
    logic ext_enable;
    logic ext_clear;
  } pcwo_chan_pins_s;

  typedef struct packed {
    logic enabled;
    logic filtered_level;
    logic [31:0] count;
  } pcwo_chan_state_s;

endpackage : pcwo_pkg

// >>> pcwo_top.sv
// Two-channel pulse counter with glitch filters, preload, freeze and two window outputs.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// One counting channel: glitch filter, gating, clear, preload and 32-bit count.
module pcwo_channel (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic sample_tick_in,
  input wire pcwo_pkg::pcwo_chan_cfg_s cfg_in,
  input wire pcwo_pkg::pcwo_chan_pins_s pins_in,
  output pcwo_pkg::pcwo_chan_state_s state_out
);
  import pcwo_pkg::*;

  logic filt_reg;
  logic filt_prev_reg;
  logic [7:0] stable_cnt_reg;
  logic [31:0] count_reg;
  logic enabled;
  logic clear_act;
  logic preload_act;
  logic pulse_edge;

  // A level change is accepted only after it has held for the selected number
  // of samples, which bounds the highest countable rate.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      filt_reg <= 1'b0;
      stable_cnt_reg <= 8'h00;
    end else if (sample_tick_in) begin
      if (pins_in.pulse != filt_reg) begin
        if ((stable_cnt_reg + 8'h01) >= cfg_in.glitch_filter_select) begin
          filt_reg <= pins_in.pulse;
          stable_cnt_reg <= 8'h00;
        end else begin
          stable_cnt_reg <= stable_cnt_reg + 8'h01;
        end
      end else begin
        stable_cnt_reg <= 8'h00;
      end
    end
  end

  // Edge detector on the filtered level; only rising edges count.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      filt_prev_reg <= 1'b0;
    end else begin
      filt_prev_reg <= filt_reg;
    end
  end

  assign pulse_edge = filt_reg & ~filt_prev_reg;
  // Software enable or a permitted external enable; a software disable cannot
  // override an active permitted external enable.
  assign enabled = cfg_in.sw_enable | (cfg_in.ext_enable_allow & pins_in.ext_enable);
  // Soft clear holds the count at zero while true; external clear only if allowed.
  assign clear_act = cfg_in.soft_clear | (cfg_in.ext_clear_allow & pins_in.ext_clear);
  // Preload only by the command or by a permitted index or limit level.
  assign preload_act = cfg_in.preload_now | (cfg_in.index_preset_allow & pins_in.index) |
                       (cfg_in.limit_preset_allow & pins_in.limit_switch_input);

  // Clear outranks preload, preload outranks freeze, freeze outranks counting.
  // The increment wraps from all ones to zero by its width.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_reg <= 32'h0000_0000;
    end else if (clear_act) begin
      count_reg <= 32'h0000_0000;
    end else if (preload_act) begin
      count_reg <= cfg_in.preload;
    end else if (cfg_in.count_freeze) begin
      count_reg <= count_reg;
    end else if (enabled && pulse_edge) begin
      count_reg <= count_reg + 32'h0000_0001;
    end
  end

  assign state_out.enabled = enabled;
  assign state_out.filtered_level = filt_reg;
  assign state_out.count = count_reg;

endmodule : pcwo_channel

// ============================================================================
// Top level: classic Wishbone slave, two channels and two window outputs.
module pcwo_top (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire pcwo_pkg::pcwo_chan_pins_s [pcwo_pkg::NUM_CH-1:0] chan_pins_in,
  input wire logic [pcwo_pkg::NUM_GP-1:0] counter_gp_input_in,
  output logic [pcwo_pkg::NUM_WIN-1:0] window_output_out
);
  import pcwo_pkg::*;

  pcwo_chan_cfg_s [NUM_CH-1:0] cfg_reg;
  pcwo_chan_state_s [NUM_CH-1:0] chan_state;
  logic [31:0] win_low_reg [NUM_WIN];
  logic [31:0] win_high_reg [NUM_WIN];
  logic [NUM_WIN-1:0] win_low_set_reg;
  logic [NUM_WIN-1:0] win_high_set_reg;
  logic [NUM_WIN-1:0] window_arm_reg;
  logic [NUM_WIN-1:0] window_on_reg;
  logic [9:0] tick_cnt_reg;
  logic sample_tick;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic bus_req;
  logic wr_go;
  logic rd_go;
  logic ch_hit;
  logic ch_idx;
  logic [4:0] ch_off;
  logic win_hit;
  logic win_idx;
  logic [3:0] win_off;

  // Byte-lane merge for 32-bit write-only values.
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] sel);
    logic [31:0] merged;
    merged = old_val;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merged[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return merged;
  endfunction : lane_merge

  // ==========================================================================
  // Sample tick shared by both filters; sharing it couples no channel state.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      tick_cnt_reg <= 10'h000;
    end else if (tick_cnt_reg == 10'(SAMPLE_CYCLES - 1)) begin
      tick_cnt_reg <= 10'h000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 10'h001;
    end
  end

  assign sample_tick = (tick_cnt_reg == 10'(SAMPLE_CYCLES - 1));

  // ==========================================================================
  // Bus decode. A request is answered one cycle after it is first seen.
  assign bus_req = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign wr_go = bus_req & wb_we_in;
  assign rd_go = bus_req & ~wb_we_in;
  assign ch_hit = (wb_adr_in[7:6] == 2'b00);
  assign ch_idx = wb_adr_in[5];
  assign ch_off = {wb_adr_in[4:2], 2'b00};
  assign win_hit = (wb_adr_in[7:5] == WIN_BASE[7:5]);
  assign win_idx = wb_adr_in[4];
  assign win_off = {wb_adr_in[3:2], 2'b00};

  // Acknowledge and read data; unmapped or write-only addresses read zero.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= bus_req;
      if (rd_go) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;

  // Read mux: counts, channel status, window states and general inputs.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (ch_hit) begin
      if (ch_off == CH_COUNT_OFF) begin
        rdata_next = chan_state[ch_idx].count;
      end else if (ch_off == CH_STATUS_OFF) begin
        rdata_next = {26'h0, chan_pins_in[ch_idx].ext_clear, chan_pins_in[ch_idx].ext_enable,
                      chan_pins_in[ch_idx].limit_switch_input, chan_pins_in[ch_idx].index,
                      chan_state[ch_idx].filtered_level, chan_state[ch_idx].enabled};
      end
    end else if (wb_adr_in == WIN_STATUS_ADDR) begin
      rdata_next = {30'h0, window_on_reg};
    end else if (wb_adr_in == GP_INPUT_ADDR) begin
      rdata_next = {26'h0, counter_gp_input_in};
    end
  end

  // ==========================================================================
  // Channel settings. The preload command is a one-cycle pulse; all other
  // bits are levels that hold until rewritten. The filter resets to 15 kHz.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_reg[c] <= '0;
        cfg_reg[c].glitch_filter_select <= FILTER_RESET;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        cfg_reg[c].preload_now <= 1'b0;
      end
      if (wr_go && ch_hit) begin
        if (ch_off == CH_CTRL_OFF && wb_sel_in[0]) begin
          cfg_reg[ch_idx].sw_enable <= wb_dat_in[CTRL_SW_ENABLE];
          cfg_reg[ch_idx].soft_clear <= wb_dat_in[CTRL_SOFT_CLEAR];
          cfg_reg[ch_idx].count_freeze <= wb_dat_in[CTRL_FREEZE];
          cfg_reg[ch_idx].index_preset_allow <= wb_dat_in[CTRL_INDEX_ALLOW];
          cfg_reg[ch_idx].limit_preset_allow <= wb_dat_in[CTRL_LIMIT_ALLOW];
          cfg_reg[ch_idx].ext_enable_allow <= wb_dat_in[CTRL_EXT_EN_ALLOW];
          cfg_reg[ch_idx].ext_clear_allow <= wb_dat_in[CTRL_EXT_CLR_ALLOW];
          cfg_reg[ch_idx].preload_now <= wb_dat_in[CTRL_PRELOAD_NOW];
        end else if (ch_off == CH_PRELOAD_OFF) begin
          cfg_reg[ch_idx].preload <= lane_merge(cfg_reg[ch_idx].preload, wb_dat_in, wb_sel_in);
        end else if (ch_off == CH_FILTER_OFF && wb_sel_in[0]) begin
          cfg_reg[ch_idx].glitch_filter_select <= wb_dat_in[7:0];
        end
      end
    end
  end

  // ==========================================================================
  // Two independent channels, each seeing only its own settings and pins.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
    pcwo_channel u_chan (
      .sys_clk_in(sys_clk_in),
      .reset_in(reset_in),
      .sample_tick_in(sample_tick),
      .cfg_in(cfg_reg[c]),
      .pins_in(chan_pins_in[c]),
      .state_out(chan_state[c])
    );
  end

  // ==========================================================================
  // Window settings. A bound counts as programmed once written after reset.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      for (int w = 0; w < NUM_WIN; w++) begin
        win_low_reg[w] <= 32'h0000_0000;
        win_high_reg[w] <= 32'h0000_0000;
      end
      win_low_set_reg <= '0;
      win_high_set_reg <= '0;
      window_arm_reg <= '0;
    end else if (wr_go && win_hit) begin
      if (win_off == WIN_LOW_OFF) begin
        win_low_reg[win_idx] <= lane_merge(win_low_reg[win_idx], wb_dat_in, wb_sel_in);
        win_low_set_reg[win_idx] <= 1'b1;
      end else if (win_off == WIN_HIGH_OFF) begin
        win_high_reg[win_idx] <= lane_merge(win_high_reg[win_idx], wb_dat_in, wb_sel_in);
        win_high_set_reg[win_idx] <= 1'b1;
      end else if (win_off == WIN_ARM_OFF && wb_sel_in[0]) begin
        window_arm_reg[win_idx] <= wb_dat_in[0];
      end
    end
  end

  // Window w watches channel w. It turns on when the count equals the low
  // bound and off when it equals the high bound; a high of zero therefore
  // acts at rollover. If both match at once the output turns off.
  for (genvar w = 0; w < NUM_WIN; w++) begin : g_win
    always_ff @(posedge sys_clk_in) begin
      if (reset_in) begin
        window_on_reg[w] <= 1'b0;
      end else if (!(window_arm_reg[w] && win_low_set_reg[w] && win_high_set_reg[w])) begin
        window_on_reg[w] <= 1'b0;
      end else if (chan_state[w].count == win_high_reg[w]) begin
        window_on_reg[w] <= 1'b0;
      end else if (chan_state[w].count == win_low_reg[w]) begin
        window_on_reg[w] <= 1'b1;
      end
    end
  end

  assign window_output_out = window_on_reg;

endmodule : pcwo_top

`default_nettype wire

// >>> pcwo_top_sva.sv
// Checker for the pulse counter bus handshake and window outputs.
`timescale 1ns/1ps
`default_nettype none
module pcwo_top_checker (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic [5:0] counter_gp_input_in,
  input wire logic [1:0] window_output_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  wire logic req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic rd = req && !wb_we_in;
  logic [1:0] lo_reg, hi_reg, arm_reg;
  wire logic [1:0] ok = lo_reg & hi_reg & arm_reg;
  // ==========
  // Tracks which windows own both range ends and an arm; half a range is not usable.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      lo_reg <= 2'h0;
      hi_reg <= 2'h0;
      arm_reg <= 2'h0;
    end else if (req && wb_we_in && wb_adr_in[7:5] == 3'h2) begin
      case (wb_adr_in[3:2])
        2'h0: lo_reg[wb_adr_in[4]] <= 1'b1;
        2'h1: hi_reg[wb_adr_in[4]] <= 1'b1;
        2'h2: arm_reg[wb_adr_in[4]] <= wb_dat_in[0];
        default: ;
      endcase
    end
  end
  // ==========
  // Properties.
  chk_ack_next: assert property (req |=> wb_ack_out)
    else $error("Request not acknowledged next cycle.");
  chk_ack_single: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("Acknowledge longer than one cycle.");
  chk_ack_cause: assert property (wb_ack_out |-> $past(req))
    else $error("Acknowledge without request.");
  chk_dat_hold: assert property ($changed(wb_dat_out) |-> $past(rd))
    else $error("Read data moved without a read.");
  chk_gp_read: assert property (rd && wb_adr_in == 8'h64 |=> wb_dat_out == {26'h0, $past(counter_gp_input_in)})
    else $error("Input levels read wrong.");
  chk_wo_zero: assert property (rd && wb_adr_in[7:4] == 4'h4 |=> wb_dat_out == 32'h0)
    else $error("Write-only place read nonzero.");
  chk_win_read: assert property (rd && wb_adr_in == 8'h60 |=> wb_dat_out == {30'h0, $past(window_output_out)})
    else $error("Window state read wrong.");
  chk_win_gate: assert property ((window_output_out & ~(ok | $past(ok))) == 2'h0)
    else $error("Window on without armed range.");
  chk_reset_quiet: assert property (disable iff (1'b0) reset_in |=> !wb_ack_out && window_output_out == 2'h0)
    else $error("Outputs active after reset.");
endmodule : pcwo_top_checker

bind pcwo_top pcwo_top_checker chk_u (
  .sys_clk_in(sys_clk_in),
  .reset_in(reset_in),
  .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in),
  .wb_adr_in(wb_adr_in),
  .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out),
  .counter_gp_input_in(counter_gp_input_in),
  .window_output_out(window_output_out)
);
`default_nettype wire

// >>> pcwo_pin_model.sv
// Model of the pulse sources, switches and external enable and clear lines.
`timescale 1ns/1ps
`default_nettype none
module pcwo_pin_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [1:0] go_in,
  input wire logic [15:0] half_in,
  input wire logic [7:0] side_in,
  output pcwo_pkg::pcwo_chan_pins_s [pcwo_pkg::NUM_CH-1:0] pins_out,
  output logic [1:0] busy_out
);
  import pcwo_pkg::*;
  logic [16:0] cnt_reg [2];
  // ==========
  // One pulse per request, high half_in cycles then low half_in + 1 cycles; callers keep half_in
  // at 1500 or more so the rate stays within 15 kHz.
  always_ff @(posedge sys_clk_in) begin
    for (int c = 0; c < 2; c++) begin
      if (reset_in) begin
        busy_out[c] <= 1'b0;
        cnt_reg[c] <= 17'h0;
      end else if (busy_out[c]) begin
        cnt_reg[c] <= cnt_reg[c] + 17'h1;
        busy_out[c] <= cnt_reg[c] != {half_in, 1'b0};
      end else if (go_in[c]) begin
        busy_out[c] <= 1'b1;
        cnt_reg[c] <= 17'h0;
      end
    end
  end
  // Each channel has its own lines, so one never disturbs the other.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pins_out[c] = {busy_out[c] && cnt_reg[c] < {1'b0, half_in}, side_in[c*4 +: 4]};
    end
  end
endmodule : pcwo_pin_model
`default_nettype wire

// >>> pcwo_top_test.sv
// Self-checking bench for the two-channel pulse counter with window outputs.
`timescale 1ns/1ps
`default_nettype none
module pcwo_top_test;
  import pcwo_pkg::*;
  logic sys_clk_in, reset_in, cyc, stb, we, ack;
  logic [7:0] adr, side;
  logic [31:0] wdat, rdat, q, pre;
  logic [5:0] gp;
  logic [1:0] go, busy, win;
  logic [15:0] half;
  pcwo_chan_pins_s [NUM_CH-1:0] pins;
  int bad_count, cmp_count, cyc_n;
  bit [31:0] e [2];
  logic [7:0] ctl [6] = '{8'h01, 8'h01, 8'h09, 8'h09, 8'h11, 8'h81};
  logic [7:0] sd [6] = '{8'h08, 8'h04, 8'h04, 8'h08, 8'h04, 8'h00};
  bit ld [6] = '{0, 0, 0, 1, 1, 1};
  pcwo_top dut_u (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we),
    .wb_adr_in(adr),
    .wb_sel_in(4'hf),
    .wb_dat_in(wdat),
    .wb_dat_out(rdat),
    .wb_ack_out(ack),
    .chan_pins_in(pins),
    .counter_gp_input_in(gp),
    .window_output_out(win)
  );
  pcwo_pin_model pin_u (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .go_in(go),
    .half_in(half),
    .side_in(side),
    .pins_out(pins),
    .busy_out(busy)
  );
  // ==========
  // Clock and hang guard; the run needs roughly 37000 cycles.
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      bad_count++;
      $display("Error %0t: run timed out", $time);
      complete_run();
    end
  end
  // ==========
  // Tasks.
  task automatic complete_run();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Holds the request until ack is seen at an edge, then releases it.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    cmp({31'h0, ack}, 32'h1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
  task automatic chk_cnt(input int c);
    xfer(1'b0, 8'(c * 32 + 12), 32'h0);
    cmp(q, e[c]);
  endtask : chk_cnt
  // Waits on the model's busy flag, bounded well past the longest pulse.
  task automatic pulse(input logic [1:0] m, input int h);
    int n;
    n = 0;
    half <= 16'(h);
    go <= m;
    @(posedge sys_clk_in);
    go <= 2'h0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (busy !== 2'h0 && n < 9000);
  endtask : pulse
  task automatic hold_side(input logic [7:0] s);
    side <= s;
    repeat (3) @(posedge sys_clk_in);
    side <= 8'h00;
  endtask : hold_side
  // ==========
  // Main sequence.
  initial begin
    {reset_in, cyc, stb, we, adr, wdat, gp, go, side} = {1'b1, 59'h0};
    half = 16'd1500;
    bad_count = 0;
    cmp_count = 0;
    cyc_n = 0;
    e = '{32'h0, 32'h0};
    void'($urandom(44801));
    repeat (12) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    gp <= 6'($urandom);
    xfer(1'b0, 8'h64, 32'h0);
    cmp(q, {26'h0, gp});
    for (int a = 0; a < 5; a++) begin
      xfer(1'b0, 8'h40 + 8'(a * 4), 32'h0);
      cmp(q, 32'h0);
    end
    xfer(1'b1, 8'h00, 32'h1);
    pulse(2'h3, 1500);
    e[0]++;
    chk_cnt(0);
    chk_cnt(1);
    xfer(1'b1, 8'h08, 32'h4);
    pulse(2'h1, 1500);
    chk_cnt(0);
    pulse(2'h1, 3300);
    e[0]++;
    chk_cnt(0);
    foreach (ctl[k]) xfer(1'b1, 8'h08, 32'(8 << k) + (k == 2 ? 32'h8 : 32'h0));
    xfer(1'b1, 8'h08, 32'h2);
    xfer(1'b1, 8'h00, 32'h5);
    pulse(2'h1, 1500);
    chk_cnt(0);
    xfer(1'b1, 8'h00, 32'h1);
    pulse(2'h1, 1500);
    e[0]++;
    chk_cnt(0);
    xfer(1'b1, 8'h00, 32'h3);
    e[0] = 0;
    chk_cnt(0);
    for (int k = 0; k < 6; k++) begin
      pre = $urandom;
      xfer(1'b1, 8'h04, pre);
      xfer(1'b1, 8'h00, {24'h0, ctl[k]});
      hold_side(sd[k]);
      if (ld[k]) e[0] = pre;
      chk_cnt(0);
    end
    side <= 8'h20;
    pulse(2'h2, 1500);
    chk_cnt(1);
    xfer(1'b1, 8'h20, 32'h21);
    xfer(1'b1, 8'h20, 32'h20);
    pulse(2'h2, 1500);
    e[1]++;
    chk_cnt(1);
    xfer(1'b0, 8'h30, 32'h0);
    cmp(q, 32'h11);
    hold_side(8'h30);
    chk_cnt(1);
    xfer(1'b1, 8'h20, 32'h60);
    hold_side(8'h30);
    e[1] = 0;
    chk_cnt(1);
    xfer(1'b1, 8'h20, 32'h1);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, 8'h24, 32'hffff_fffe);
      xfer(1'b1, 8'h20, 32'h81);
      xfer(1'b1, 8'h50, 32'hffff_ffff);
      xfer(1'b1, 8'h54, 32'h0);
      xfer(1'b1, 8'h58, 32'(k));
      pulse(2'h2, 1500);
      e[1] = 32'hffff_ffff;
      cmp({30'h0, win}, 32'(k * 2));
    end
    xfer(1'b0, 8'h60, 32'h0);
    cmp(q, 32'h2);
    pulse(2'h2, 1500);
    cmp({30'h0, win}, 32'h0);
    e[1]++;
    chk_cnt(1);
    chk_cnt(0);
    // Window 0 armed with only its low bound written must stay off at the match.
    xfer(1'b1, 8'h40, e[0] + 32'h1);
    xfer(1'b1, 8'h48, 32'h1);
    pulse(2'h1, 1500);
    e[0]++;
    cmp({30'h0, win}, 32'h0);
    chk_cnt(0);
    complete_run();
  end
endmodule : pcwo_top_test
`default_nettype wire
